/* File: hw/paq_action_qualifier.v */
// pwm time base, compare shadowing and action qualifier with apb slave
`include "paq_consts.vh"

// What this block does
// - up mode: compare-up only if compare <= period
// - down mode: compare-down, at period if compare >= period
// - up-down rising: compare-up, else at period
// - up-down falling: compare-down only if compare < period
// - down mode: period event has lowest priority
// - shadow to active once, at zero or period
// - events use active values only
// - new compare may act one period late
// - symmetric compare 0 low, period high
// - up mode wraps period to zero
// - set zero, clear compare-up gives active high
// - clear period, set compare-up gives active low
// - pulse placement between two compares
// - output b toggles for half-rate square wave
// - four actions: set, clear, toggle, nothing
// - all actions reset to nothing
// - down mode order: force, zero, cbd, cad, period
module paq_action_qualifier #(
   parameter W = 16
) (
   input  wire          pclk,
   input  wire          presetn,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [7:0]    paddr,
   input  wire [31:0]   pwdata,
   output reg  [31:0]   prdata,
   output wire          pready,
   output wire          pslverr,
   output reg           pwm_output_a,
   output reg           pwm_output_b,
   output reg  [W-1:0]  timebase_counter
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // apply one action to the current output level
   function apply_act;
      input       cur;
      input [1:0] act;
      begin
         case (act)
            `PAQ_ACT_CLEAR:  apply_act = 1'b0;
            `PAQ_ACT_SET:    apply_act = 1'b1;
            `PAQ_ACT_TOGGLE: apply_act = ~cur;
            default:         apply_act = cur;
         endcase
      end
   endfunction

   // highest-priority firing event with a real action wins;
   // ev[5] and a5 are the highest priority
   function [1:0] pick;
      input [5:0] ev;
      input [1:0] a5;
      input [1:0] a4;
      input [1:0] a3;
      input [1:0] a2;
      input [1:0] a1;
      input [1:0] a0;
      begin
         pick = `PAQ_ACT_NONE;
         if (ev[0] && a0 != `PAQ_ACT_NONE) pick = a0;
         if (ev[1] && a1 != `PAQ_ACT_NONE) pick = a1;
         if (ev[2] && a2 != `PAQ_ACT_NONE) pick = a2;
         if (ev[3] && a3 != `PAQ_ACT_NONE) pick = a3;
         if (ev[4] && a4 != `PAQ_ACT_NONE) pick = a4;
         if (ev[5] && a5 != `PAQ_ACT_NONE) pick = a5;
      end
   endfunction

   // compare event, up variant (want_up=1) or down variant
   function cmp_ev;
      input [1:0]   mode;
      input         dir_up;
      input         want_up;
      input [W-1:0] ctr;
      input [W-1:0] cmp;
      input [W-1:0] period_action_field;
      begin
         cmp_ev = 1'b0;
         case (mode)
            `PAQ_MODE_UP:
               // above period never fires; no down events
               cmp_ev = want_up && ctr == cmp && cmp <= period_action_field;
            `PAQ_MODE_DOWN:
               cmp_ev = !want_up &&
                        ((cmp < period_action_field) ? ctr == cmp
                                     : ctr == period_action_field);
            `PAQ_MODE_UPDOWN:
               // direction of this same tick picks the variant
               cmp_ev = (want_up == dir_up) &&
                        ((cmp < period_action_field) ? ctr == cmp
                                     : ctr == period_action_field);
            default:
               cmp_ev = 1'b0;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg  [5:0]   ctrl_q;
   reg  [W-1:0] period_value;
   reg  [W-1:0] cmp_a_shadow_q;
   reg  [W-1:0] cmp_b_shadow_q;
   reg  [W-1:0] compare_a_value;
   reg  [W-1:0] compare_b_value;
   reg  [11:0]  act_a_q;
   reg  [11:0]  act_b_q;
   reg          dir_up_q;

   wire [1:0]   count_direction_mode;
   wire         cmp_a_shadow_enable;
   wire         cmp_b_shadow_enable;
   wire         cmp_a_load_select;
   wire         cmp_b_load_select;

   assign count_direction_mode =
      ctrl_q[`PAQ_CTRL_MODE_HI:`PAQ_CTRL_MODE_LO];
   assign cmp_a_shadow_enable = ctrl_q[`PAQ_CTRL_SHA];
   assign cmp_b_shadow_enable = ctrl_q[`PAQ_CTRL_SHB];
   assign cmp_a_load_select   = ctrl_q[`PAQ_CTRL_LDA];
   assign cmp_b_load_select   = ctrl_q[`PAQ_CTRL_LDB];

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   wire       wr_acc;
   wire       mapped;
   wire       wr_ok;
   reg [31:0] rd_d;

   // registers answer at once, so the access phase is one cycle
   assign pready  = 1'b1;
   assign mapped  = paddr[1:0] == 2'b00 && paddr[7:5] == 3'b000;
   assign pslverr = psel & penable & ~mapped;
   assign wr_acc  = psel & penable & pwrite;
   assign wr_ok   = wr_acc & mapped;

   wire wr_ctrl  = wr_ok && paddr == `PAQ_OFS_CTRL;
   wire wr_prd   = wr_ok && paddr == `PAQ_OFS_PERIOD;
   wire wr_compare_a_value  = wr_ok && paddr == `PAQ_OFS_COMPARE_A_VALUE;
   wire wr_compare_b_value  = wr_ok && paddr == `PAQ_OFS_COMPARE_B_VALUE;
   wire wr_acta  = wr_ok && paddr == `PAQ_OFS_ACTA;
   wire wr_actb  = wr_ok && paddr == `PAQ_OFS_ACTB;
   wire wr_force = wr_ok && paddr == `PAQ_OFS_FORCE;

   // read mux; compare offsets show the value software wrote
   always @* begin
      rd_d = 32'h0000_0000;
      case (paddr)
         `PAQ_OFS_CTRL:   rd_d[5:0] = ctrl_q;
         `PAQ_OFS_PERIOD: rd_d[W-1:0] = period_value;
         `PAQ_OFS_COMPARE_A_VALUE:   rd_d[W-1:0] = cmp_a_shadow_q;
         `PAQ_OFS_COMPARE_B_VALUE:   rd_d[W-1:0] = cmp_b_shadow_q;
         `PAQ_OFS_ACTA:   rd_d[11:0] = act_a_q;
         `PAQ_OFS_ACTB:   rd_d[11:0] = act_b_q;
         `PAQ_OFS_STATUS: begin
            rd_d[W-1:0] = timebase_counter;
            rd_d[`PAQ_STAT_DIR]  = dir_up_q;
            rd_d[`PAQ_STAT_OUTA] = pwm_output_a;
            rd_d[`PAQ_STAT_OUTB] = pwm_output_b;
         end
         default:         rd_d = 32'h0000_0000;
      endcase
   end

   // read data captured in the setup cycle, stable in access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_d;
      end
   end

   // ----------------------------------------------------------------
   // time base counter
   // ----------------------------------------------------------------
   wire running = count_direction_mode != `PAQ_MODE_STOP;
   wire at_zero = timebase_counter == {W{1'b0}};
   wire at_prd  = timebase_counter == period_value;
   wire go_up   = dir_up_q ? !at_prd : at_zero;

   // up-down: values reached by counting up are "incrementing",
   // so the period point is an up tick and zero a down tick
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timebase_counter <= {W{1'b0}};
         dir_up_q         <= 1'b0;
      end else begin
         case (count_direction_mode)
            `PAQ_MODE_UP: begin
               dir_up_q <= 1'b1;
               // wraps from period to zero: period+1 ticks
               if (timebase_counter >= period_value)
                  timebase_counter <= {W{1'b0}};
               else
                  timebase_counter <= timebase_counter + 1'b1;
            end
            `PAQ_MODE_DOWN: begin
               dir_up_q <= 1'b0;
               if (at_zero || timebase_counter > period_value)
                  timebase_counter <= period_value;
               else
                  timebase_counter <= timebase_counter - 1'b1;
            end
            `PAQ_MODE_UPDOWN: begin
               if (period_value == {W{1'b0}}) begin
                  timebase_counter <= {W{1'b0}};
               end else if (timebase_counter > period_value) begin
                  timebase_counter <= period_value;
                  dir_up_q         <= 1'b1;
               end else if (go_up) begin
                  timebase_counter <= timebase_counter + 1'b1;
                  dir_up_q         <= 1'b1;
               end else begin
                  timebase_counter <= timebase_counter - 1'b1;
                  dir_up_q         <= 1'b0;
               end
            end
            default: ; // stopped: counter frozen
         endcase
      end
   end

   // ----------------------------------------------------------------
   // configuration and compare shadowing
   // ----------------------------------------------------------------
   // a shadowed compare moves to active only at the chosen point,
   // once per period; a change can therefore lag one period
   wire ld_a = running && cmp_a_shadow_enable &&
               (cmp_a_load_select ? at_prd : at_zero);
   wire ld_b = running && cmp_b_shadow_enable &&
               (cmp_b_load_select ? at_prd : at_zero);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q          <= `PAQ_CTRL_RST;
         period_value    <= `PAQ_PERIOD_RST;
         cmp_a_shadow_q  <= `PAQ_CMP_RST;
         cmp_b_shadow_q  <= `PAQ_CMP_RST;
         compare_a_value <= `PAQ_CMP_RST;
         compare_b_value <= `PAQ_CMP_RST;
         act_a_q         <= `PAQ_ACTREG_RST;
         act_b_q         <= `PAQ_ACTREG_RST;
      end else begin
         if (wr_ctrl) ctrl_q <= pwdata[5:0];
         if (wr_prd)  period_value <= pwdata[W-1:0];
         if (wr_acta) act_a_q <= pwdata[11:0];
         if (wr_actb) act_b_q <= pwdata[11:0];
         if (wr_compare_a_value) cmp_a_shadow_q <= pwdata[W-1:0];
         if (wr_compare_b_value) cmp_b_shadow_q <= pwdata[W-1:0];
         // immediate mode writes the active value directly
         if (wr_compare_a_value && !cmp_a_shadow_enable)
            compare_a_value <= pwdata[W-1:0];
         else if (ld_a)
            compare_a_value <= cmp_a_shadow_q;
         if (wr_compare_b_value && !cmp_b_shadow_enable)
            compare_b_value <= pwdata[W-1:0];
         else if (ld_b)
            compare_b_value <= cmp_b_shadow_q;
      end
   end

   // ----------------------------------------------------------------
   // event qualification, from active values only
   // ----------------------------------------------------------------
   wire [1:0] md = count_direction_mode;
   wire [W-1:0] ctr = timebase_counter;
   wire ev_zero = running && at_zero;
   wire ev_prd  = running && at_prd;
   wire ev_cau  = running &&
      cmp_ev(md, dir_up_q, 1'b1, ctr, compare_a_value, period_value);
   wire ev_cad  = running &&
      cmp_ev(md, dir_up_q, 1'b0, ctr, compare_a_value, period_value);
   wire ev_cbu  = running &&
      cmp_ev(md, dir_up_q, 1'b1, ctr, compare_b_value, period_value);
   wire ev_cbd  = running &&
      cmp_ev(md, dir_up_q, 1'b0, ctr, compare_b_value, period_value);

   // ----------------------------------------------------------------
   // priority resolution per output
   // ----------------------------------------------------------------
   // resolve one output's action from its own action register
   function [1:0] resolve;
      input [11:0] c;
      input [1:0]  mode;
      input        up;
      reg   [1:0]  z;
      reg   [1:0]  p;
      reg   [1:0]  au;
      reg   [1:0]  ad;
      reg   [1:0]  bu;
      reg   [1:0]  bd;
      begin
         z  = c[`PAQ_FLD_ZERO+1:`PAQ_FLD_ZERO];
         p  = c[`PAQ_FLD_PRD+1:`PAQ_FLD_PRD];
         au = c[`PAQ_FLD_CAU+1:`PAQ_FLD_CAU];
         ad = c[`PAQ_FLD_CAD+1:`PAQ_FLD_CAD];
         bu = c[`PAQ_FLD_CBU+1:`PAQ_FLD_CBU];
         bd = c[`PAQ_FLD_CBD+1:`PAQ_FLD_CBD];
         case (mode)
            `PAQ_MODE_UP:
               resolve = pick({ev_prd, ev_cbu, ev_cau, ev_zero,
                               2'b00}, p, bu, au, z,
                              `PAQ_ACT_NONE, `PAQ_ACT_NONE);
            `PAQ_MODE_DOWN:
               // period last of all
               resolve = pick({ev_zero, ev_cbd, ev_cad, ev_prd,
                               2'b00}, z, bd, ad, p,
                              `PAQ_ACT_NONE, `PAQ_ACT_NONE);
            `PAQ_MODE_UPDOWN:
               // this direction's compares win, b over a; then zero over period counting up, period over zero counting down
               resolve = up ?
                  pick({ev_cbu, ev_cau, ev_zero, ev_prd, ev_cbd,
                        ev_cad}, bu, au, z, p, bd, ad) :
                  pick({ev_cbd, ev_cad, ev_prd, ev_zero, ev_cbu,
                        ev_cau}, bd, ad, p, z, bu, au);
            default:
               resolve = `PAQ_ACT_NONE;
         endcase
      end
   endfunction

   wire [1:0] act_a = resolve(act_a_q, md, dir_up_q);
   wire [1:0] act_b = resolve(act_b_q, md, dir_up_q);

   // software force outranks every counter event
   wire       frc_a  = wr_force && pwdata[`PAQ_FRC_GOA];
   wire       frc_b  = wr_force && pwdata[`PAQ_FRC_GOB];
   wire [1:0] fact_a = pwdata[`PAQ_FRC_ACTA_LO+1:`PAQ_FRC_ACTA_LO];
   wire [1:0] fact_b = pwdata[`PAQ_FRC_ACTB_LO+1:`PAQ_FRC_ACTB_LO];

   // ----------------------------------------------------------------
   // outputs, one update per tick
   // ----------------------------------------------------------------
   // set/clear/toggle/nothing on each output from its own winner;
   // zero-set with compare-clear gives active high, period-clear
   // with compare-set active low, two compares place a pulse and a
   // zero toggle gives a half-rate square wave
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_output_a <= 1'b0;
         pwm_output_b <= 1'b0;
      end else begin
         if (frc_a)
            pwm_output_a <= apply_act(pwm_output_a, fact_a);
         else
            pwm_output_a <= apply_act(pwm_output_a, act_a);
         if (frc_b)
            pwm_output_b <= apply_act(pwm_output_b, fact_b);
         else
            pwm_output_b <= apply_act(pwm_output_b, act_b);
      end
   end

endmodule // paq_action_qualifier

/* File: hw/paq_consts.vh */
// constants of the pwm action-qualifier block
`ifndef PAQ_CONSTS_VH
`define PAQ_CONSTS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PAQ_OFS_CTRL    8'h00
`define PAQ_OFS_PERIOD  8'h04
`define PAQ_OFS_COMPARE_A_VALUE    8'h08
`define PAQ_OFS_COMPARE_B_VALUE    8'h0c
`define PAQ_OFS_ACTA    8'h10
`define PAQ_OFS_ACTB    8'h14
`define PAQ_OFS_FORCE   8'h18
`define PAQ_OFS_STATUS  8'h1c
// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define PAQ_CTRL_MODE_LO 0
`define PAQ_CTRL_MODE_HI 1
`define PAQ_CTRL_SHA     2
`define PAQ_CTRL_SHB     3
`define PAQ_CTRL_LDA     4
`define PAQ_CTRL_LDB     5
`define PAQ_CTRL_RST     6'h0f
// ----------------------------------------------------------------
// count direction modes
// ----------------------------------------------------------------
`define PAQ_MODE_UP      2'h0
`define PAQ_MODE_DOWN    2'h1
`define PAQ_MODE_UPDOWN  2'h2
`define PAQ_MODE_STOP    2'h3
// ----------------------------------------------------------------
// action codes and action register field positions
// ----------------------------------------------------------------
`define PAQ_ACT_NONE     2'h0
`define PAQ_ACT_CLEAR    2'h1
`define PAQ_ACT_SET      2'h2
`define PAQ_ACT_TOGGLE   2'h3
`define PAQ_FLD_ZERO     0
`define PAQ_FLD_PRD      2
`define PAQ_FLD_CAU      4
`define PAQ_FLD_CAD      6
`define PAQ_FLD_CBU      8
`define PAQ_FLD_CBD      10
`define PAQ_ACTREG_RST   12'h000
// ----------------------------------------------------------------
// force and status register fields and other reset values
// ----------------------------------------------------------------
`define PAQ_FRC_ACTA_LO  0
`define PAQ_FRC_GOA      2
`define PAQ_FRC_ACTB_LO  3
`define PAQ_FRC_GOB      5
`define PAQ_STAT_DIR     16
`define PAQ_STAT_OUTA    17
`define PAQ_STAT_OUTB    18
`define PAQ_PERIOD_RST   16'h0000
`define PAQ_CMP_RST      16'h0000
`endif

/* File: testbench/paq_aq_properties.sv */
// concurrent checks on the pwm action qualifier ports
`include "paq_consts.vh"
module paq_aq_properties #(
   parameter W = 16
) (
   input wire          pclk,
   input wire          presetn,
   input wire          psel,
   input wire          penable,
   input wire          pwrite,
   input wire [7:0]    paddr,
   input wire [31:0]   pwdata,
   input wire          pready,
   input wire          pwm_output_a,
   input wire          pwm_output_b,
   input wire [W-1:0]  timebase_counter
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0]    mode_q;
   logic [11:0]   acta_q;
   logic [11:0]   actb_q;
   logic [W-1:0]  prd_q;
   wire           wr  = psel & penable & pwrite & pready;
   wire           frc = wr && paddr == `PAQ_OFS_FORCE;
   wire           up  = mode_q == `PAQ_MODE_UP;
   wire           dn  = mode_q == `PAQ_MODE_DOWN;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // copy of the writes that shape the waveform; only what checks need
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= `PAQ_MODE_STOP;
         acta_q <= `PAQ_ACTREG_RST;
         actb_q <= `PAQ_ACTREG_RST;
         prd_q  <= `PAQ_PERIOD_RST;
      end else if (wr) begin
         if (paddr == `PAQ_OFS_CTRL) mode_q <= pwdata[1:0];
         if (paddr == `PAQ_OFS_PERIOD) prd_q <= pwdata[W-1:0];
         if (paddr == `PAQ_OFS_ACTA) acta_q <= pwdata[11:0];
         if (paddr == `PAQ_OFS_ACTB) actb_q <= pwdata[11:0];
      end
   end

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_up_wrap;
      up && timebase_counter == prd_q |=> timebase_counter == '0;
   endproperty
   a_up_wrap: assert property (p_up_wrap) else $error("no wrap");
   property p_up_step;
      up && timebase_counter < prd_q
         |=> timebase_counter == $past(timebase_counter) + 1'b1;
   endproperty
   a_up_step: assert property (p_up_step) else $error("bad step");
   property p_idle_a;
      acta_q == `PAQ_ACTREG_RST && !frc |=> $stable(pwm_output_a);
   endproperty
   a_idle_a: assert property (p_idle_a) else $error("a moved");
   property p_idle_b;
      actb_q == `PAQ_ACTREG_RST && !frc |=> $stable(pwm_output_b);
   endproperty
   a_idle_b: assert property (p_idle_b) else $error("b moved");
   property p_rise_zero;
      $rose(pwm_output_a) && $past(up && acta_q == 12'h012 && !frc)
         |-> $past(timebase_counter) == '0;
   endproperty
   a_rise_zero: assert property (p_rise_zero) else $error("a rise");
   property p_fall_prd;
      $fell(pwm_output_a) && $past(up && acta_q == 12'h024 && !frc)
         |-> $past(timebase_counter) == $past(prd_q);
   endproperty
   a_fall_prd: assert property (p_fall_prd) else $error("a fall");
   property p_tog_b;
      up && actb_q == 12'h003 && !frc && timebase_counter == '0
         |=> pwm_output_b != $past(pwm_output_b);
   endproperty
   a_tog_b: assert property (p_tog_b) else $error("no toggle");
   property p_no_cad_up;
      up && acta_q == 12'h0c0 && !frc |=> $stable(pwm_output_a);
   endproperty
   a_no_cad_up: assert property (p_no_cad_up) else $error("cad");
   property p_no_cau_dn;
      dn && acta_q == 12'h030 && !frc |=> $stable(pwm_output_a);
   endproperty
   a_no_cau_dn: assert property (p_no_cau_dn) else $error("cau");
endmodule // paq_aq_properties

bind paq_action_qualifier paq_aq_properties #(.W(W)) u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pwm_output_a(pwm_output_a), .pwm_output_b(pwm_output_b),
   .timebase_counter(timebase_counter)
);

/* File: testbench/paq_switch_drv.sv */
// model of the two gate drivers fed by the pwm outputs
module paq_switch_drv (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clr,
   input  wire logic        gate_a,
   input  wire logic        gate_b,
   output logic [15:0]      on_a,
   output logic [15:0]      on_b
);
   timeunit 1ns;
   timeprecision 100ps;
   // on-time totals in whole ticks; a sliver under one tick goes unseen,
   // as it would at a real driver input
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_a <= 16'h0;
         on_b <= 16'h0;
      end else if (clr) begin
         on_a <= 16'h0;
         on_b <= 16'h0;
      end else begin
         on_a <= on_a + {15'h0, gate_a};
         on_b <= on_b + {15'h0, gate_b};
      end
   end
endmodule // paq_switch_drv

/* File: testbench/pwm_action_qualifier_compare_test.sv */
// self-checking bench of the pwm action qualifier
`include "paq_consts.vh"
module pwm_action_qualifier_compare_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic         pclk = 1'b0;
   logic         presetn = 1'b0;
   logic         psel = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic [31:0]  pwdata = 32'h0;
   logic         clr = 1'b0;
   logic         perr;
   logic [31:0]  rd;
   wire  [31:0]  prdata;
   wire          pready;
   wire          pslverr;
   wire          pwm_output_a;
   wire          pwm_output_b;
   wire  [15:0]  timebase_counter;
   wire  [15:0]  on_a;
   wire  [15:0]  on_b;
   int           bad_count = 0;
   int           cmp_count = 0;
   int           cyc = 0;

   paq_action_qualifier #(.W(16)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pwm_output_a(pwm_output_a),
      .pwm_output_b(pwm_output_b), .timebase_counter(timebase_counter)
   );
   paq_switch_drv drv (
      .pclk(pclk), .presetn(presetn), .clr(clr), .gate_a(pwm_output_a),
      .gate_b(pwm_output_b), .on_a(on_a), .on_b(on_b)
   );

   always #2.5 pclk = ~pclk;

   // hang guard; a clean run needs well under 2000 ticks
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         bad_count++;
         close_out();
      end
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd   = prdata;
      perr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // settle, then on-time over len ticks; len is whole periods so the
   // phase at which counting starts does not matter
   task automatic duty(input int len, input logic [15:0] ea, eb);
      repeat (len) @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      repeat (len) @(posedge pclk);
      @(negedge pclk);
      chk("on time a", {16'h0, on_a}, {16'h0, ea});
      chk("on time b", {16'h0, on_b}, {16'h0, eb});
   endtask

   task automatic wait_ctr(input logic [15:0] v);
      do @(negedge pclk); while (timebase_counter !== v);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      logic [7:0]  ra[4] = '{`PAQ_OFS_CTRL, `PAQ_OFS_ACTA, `PAQ_OFS_ACTB,
                             `PAQ_OFS_COMPARE_A_VALUE};
      logic [31:0] re[4] = '{32'hf, 32'h0, 32'h0, 32'h0};
      foreach (ra[i]) begin
         apb(1'b0, ra[i], 32'h0);
         chk("reset value", rd, re[i]);
      end
      apb(1'b1, 8'h22, 32'h1);
      chk("unmapped error", {31'h0, perr}, 32'h1);
      $display("reset test done");
   endtask

   // counter stopped, so only software force moves the outputs
   task automatic t_force;
      logic [7:0] fd[6] = '{8'h2d, 8'h06, 8'h30, 8'h07, 8'h04, 8'h38};
      logic [1:0] fe[6] = '{2'h0, 2'h2, 2'h3, 2'h1, 2'h1, 2'h0};
      apb(1'b1, `PAQ_OFS_CTRL, 32'hf);
      foreach (fd[i]) begin
         apb(1'b1, `PAQ_OFS_FORCE, {24'h0, fd[i]});
         @(negedge pclk);
         chk("forced a b", {30'h0, pwm_output_a, pwm_output_b},
             {30'h0, fe[i]});
      end
      $display("force test done");
   endtask

   task automatic t_up;
      logic [11:0] ac[6] = '{12'h120, 12'h024, 12'h012, 12'h012, 12'h012,
                             12'h0c0};
      logic [15:0] cm[6] = '{16'h3, 16'h4, 16'h0, 16'h4, 16'ha, 16'h4};
      logic [15:0] ea[6] = '{16'h8, 16'ha, 16'h0, 16'h8, 16'h14, 16'h14};
      apb(1'b1, `PAQ_OFS_CTRL, 32'h3c);
      apb(1'b1, `PAQ_OFS_PERIOD, 32'h9);
      apb(1'b1, `PAQ_OFS_COMPARE_B_VALUE, 32'h7);
      apb(1'b1, `PAQ_OFS_ACTB, 32'h3);
      foreach (ac[i]) begin
         apb(1'b1, `PAQ_OFS_ACTA, {20'h0, ac[i]});
         apb(1'b1, `PAQ_OFS_COMPARE_A_VALUE, {16'h0, cm[i]});
         duty(20, ea[i], 16'ha);
      end
      $display("up-count test done");
   endtask

   // compare written mid-period: shadowed waits for zero, direct acts now
   task automatic t_shadow;
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, `PAQ_OFS_CTRL, i ? 32'h0 : 32'hc);
         apb(1'b1, `PAQ_OFS_ACTA, 32'h12);
         apb(1'b1, `PAQ_OFS_COMPARE_A_VALUE, 32'h4);
         repeat (25) @(posedge pclk);
         wait_ctr(16'h0);
         apb(1'b1, `PAQ_OFS_COMPARE_A_VALUE, 32'h8);
         wait_ctr(16'h6);
         chk("old compare", {31'h0, pwm_output_a},
             i ? 32'h1 : 32'h0);
         wait_ctr(16'h6);
         chk("new compare", {31'h0, pwm_output_a}, 32'h1);
      end
      $display("shadow test done");
   endtask

   task automatic t_updn;
      logic [7:0]  ct[6] = '{8'h0e, 8'h0e, 8'h0e, 8'h0e, 8'h3e, 8'h3e};
      logic [11:0] ac[6] = '{12'h060, 12'h060, 12'h060, 12'h060, 12'h024,
                             12'h024};
      logic [15:0] cm[6] = '{16'h3, 16'h0, 16'h8, 16'h9, 16'h3, 16'h6};
      logic [15:0] ea[6] = '{16'h14, 16'h0, 16'h20, 16'h20, 16'ha, 16'h4};
      apb(1'b1, `PAQ_OFS_PERIOD, 32'h8);
      foreach (ac[i]) begin
         apb(1'b1, `PAQ_OFS_CTRL, {24'h0, ct[i]});
         apb(1'b1, `PAQ_OFS_ACTA, {20'h0, ac[i]});
         apb(1'b1, `PAQ_OFS_COMPARE_A_VALUE, {16'h0, cm[i]});
         // period-loaded compares stay at or below period-1
         duty(32, ea[i], 16'h10);
      end
      $display("up-down test done");
   endtask

   task automatic t_down;
      logic [11:0] ac[5] = '{12'h081, 12'h081, 12'h085, 12'h081, 12'h030};
      logic [15:0] cm[5] = '{16'h4, 16'h9, 16'hc, 16'h0, 16'h4};
      logic [15:0] ea[5] = '{16'h8, 16'h12, 16'h12, 16'h0, 16'h0};
      apb(1'b1, `PAQ_OFS_PERIOD, 32'h9);
      apb(1'b1, `PAQ_OFS_CTRL, 32'hd);
      foreach (ac[i]) begin
         apb(1'b1, `PAQ_OFS_ACTA, {20'h0, ac[i]});
         apb(1'b1, `PAQ_OFS_COMPARE_A_VALUE, {16'h0, cm[i]});
         duty(20, ea[i], 16'ha);
      end
      $display("down-count test done");
   endtask

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_force();
      t_up();
      t_shadow();
      t_updn();
      t_down();
      close_out();
   end
endmodule // pwm_action_qualifier_compare_test
